// >>> include/stc_defs.vh
`ifndef STC_DEFS_VH
`define STC_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define STC_ADDR_W 4
`define STC_OFF_NARROW_CTRL 4'h0
`define STC_OFF_SHARED_CTRL 4'h1
`define STC_OFF_WIDE_CTRL 4'h2
`define STC_OFF_IRQ_STATUS 4'h3
`define STC_OFF_IRQ_MASK 4'h4
`define STC_OFF_TIMER_STATE 4'h5
// ****************************************
// shared control field positions
// ****************************************
`define STC_B_MODE 0
`define STC_B_INSEL 1
`define STC_B_PINEN 1
`define STC_F_EDGE_LO 2
`define STC_F_EDGE_HI 3
`define STC_F_FILT_LO 4
`define STC_F_FILT_HI 5
`define STC_B_NARROW_INIT 6
`define STC_B_RISE 6
`define STC_B_WIDE_INIT 7
`define STC_B_FALL 7
// ****************************************
// encodings and reset values
// ****************************************
`define STC_OUT_NORMAL 2'h0
`define STC_OUT_PINGPONG 2'h1
`define STC_OUT_FORCE0 2'h2
`define STC_OUT_FORCE1 2'h3
`define STC_LOGIC_AND 2'h0
`define STC_LOGIC_OR 2'h1
`define STC_LOGIC_NOR 2'h2
`define STC_EDGE_FALL 2'h0
`define STC_EDGE_RISE 2'h1
`define STC_EDGE_BOTH 2'h2
`define STC_FILT_NONE 2'h0
`define STC_FILT_4 2'h1
`define STC_FILT_8 2'h2
`define STC_FILT4_CYC 4'h4
`define STC_FILT8_CYC 4'h8
`define STC_RST_BYTE 8'h00
`define STC_IRQ_FALL 0
`define STC_IRQ_RISE 1
`endif

// >>> rtl/stc_sync.v
// ****************************************
// two-stage synchroniser for a pin input
// ****************************************
module stc_sync (
    input wire clk_sys, // system clock
    input wire rstn, // async reset, active low
    input wire d, // asynchronous pin level
    output reg q // synchronised level
);
    reg meta;
    // first stage feeds only the second
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // stc_sync

// >>> rtl/stc_filter.v
`include "stc_defs.vh"
// ****************************************
// glitch filter: level must hold n cycles
// ****************************************
module stc_filter (
    input wire clk_sys, // system clock
    input wire rstn, // async reset, active low
    input wire [1:0] sel, // filter length select
    input wire d, // synchronised input
    output reg q // filtered level
);
    reg [3:0] cnt;
    reg [3:0] need;
    // required stable cycles for the selected setting
    always @* begin
        case (sel)
            `STC_FILT_4: need = `STC_FILT4_CYC;
            `STC_FILT_8: need = `STC_FILT8_CYC;
            default: need = 4'h0;
        endcase
    end
    // count cycles the input differs from output, adopt when long enough
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            q <= 1'b0;
        end else if (d == q) begin
            cnt <= 4'h0;
        end else if (need == 4'h0 || cnt + 4'h1 >= need) begin
            q <= d;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // stc_filter

// >>> rtl/stc_ctrl.v
`include "stc_defs.vh"
// How it works
// - bit 0 picks transmit (0, reset) or demodulation (1); stop timers first
// - transmit: bit 7 gives starting level of wide timer output
// - transmit: bit 6 gives starting level of narrow timer output
// - demod: falling edge sets bit 7 flag; writing 1 clears it
// - demod: rising edge sets bit 6 flag; writing 1 clears it
// - transmit: bits 5:4 pick normal, ping-pong, force wide low, force high
// - demod: bits 5:4 pick no filter, 4-cycle, 8-cycle filter, reserved
// - demod: bits 3:2 pick falling, rising, both edges, reserved
// - transmit: bit 1 routes combined timer output to the output pin
// - demod: bit 1 picks input pin a (0) or pin b (1)
module stc_ctrl (
    input wire clk_sys, // system clock, 250 MHz
    input wire rstn, // async reset, active low
    input wire [3:0] addr, // register address
    input wire [7:0] wdata, // write data
    input wire wr, // write strobe
    input wire rd, // read strobe
    output reg [7:0] rdata, // read data, cycle after rd
    input wire narrow_timer_output, // narrow counter raw output
    input wire wide_timer_output, // wide counter raw output
    input wire narrow_run, // narrow counter running
    input wire wide_run, // wide counter running
    input wire port_out_val, // ordinary port latch value
    input wire demod_input_pin_a, // demod pin a, asynchronous
    input wire demod_input_pin_b, // demod pin b, asynchronous
    output reg [7:0] narrow_timer_control, // narrow counter control
    output reg [7:0] wide_timer_control, // wide counter control
    output wire demod_mode, // 1 while demodulation mode
    output wire narrow_init, // narrow output start level
    output wire wide_init, // wide output start level
    output wire pingpong, // ping-pong operation selected
    output reg demod_edge, // pulse on a selected edge
    output reg timer_output_pin, // output pin level
    output wire timer_output_pin_oe, // output pin enable
    output wire irq // level interrupt
);
    reg [7:0] shared_timer_ctrl;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg fall_flag;
    reg rise_flag;
    reg filt_prev;
    reg comb;
    reg wide_eff;
    reg [7:0] next_rdata;
    wire sync_a;
    wire sync_b;
    wire filt_q;
    wire mode = shared_timer_ctrl[`STC_B_MODE];
    wire [1:0] f54 = shared_timer_ctrl[`STC_F_FILT_HI:`STC_F_FILT_LO];
    wire [1:0] f32 = shared_timer_ctrl[`STC_F_EDGE_HI:`STC_F_EDGE_LO];
    wire wr_shared = wr && addr == `STC_OFF_SHARED_CTRL;
    wire fall_ev;
    wire rise_ev;

    // ****************************************
    // input pins and filtering
    // ****************************************
    stc_sync u_sync_a (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(demod_input_pin_a),
        .q(sync_a)
    );
    stc_sync u_sync_b (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(demod_input_pin_b),
        .q(sync_b)
    );
    stc_filter u_filter (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sel(mode ? f54 : `STC_FILT_NONE),
        .d(shared_timer_ctrl[`STC_B_INSEL] ? sync_b : sync_a),
        .q(filt_q)
    );

    // edge detect with the selected polarity
    assign fall_ev = mode && filt_prev && !filt_q
        && (f32 == `STC_EDGE_FALL || f32 == `STC_EDGE_BOTH);
    assign rise_ev = mode && !filt_prev && filt_q
        && (f32 == `STC_EDGE_RISE || f32 == `STC_EDGE_BOTH);

    // ****************************************
    // mode outputs
    // ****************************************
    assign demod_mode = mode;
    assign wide_init = !mode && shared_timer_ctrl[`STC_B_WIDE_INIT];
    assign narrow_init = !mode && shared_timer_ctrl[`STC_B_NARROW_INIT];
    assign pingpong = !mode && f54 == `STC_OUT_PINGPONG;
    assign timer_output_pin_oe = 1'b1;
    assign irq = |(irq_status & irq_mask);

    // wide output override and combining logic
    always @* begin
        case (f54)
            `STC_OUT_FORCE0: wide_eff = 1'b0;
            `STC_OUT_FORCE1: wide_eff = 1'b1;
            default: wide_eff = wide_timer_output;
        endcase
        case (f32)
            `STC_LOGIC_AND: comb = narrow_timer_output & wide_eff;
            `STC_LOGIC_OR: comb = narrow_timer_output | wide_eff;
            `STC_LOGIC_NOR: comb = ~(narrow_timer_output | wide_eff);
            default: comb = ~(narrow_timer_output & wide_eff);
        endcase
    end

    // ****************************************
    // registers and flags
    // ****************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shared_timer_ctrl <= `STC_RST_BYTE;
            narrow_timer_control <= `STC_RST_BYTE;
            wide_timer_control <= `STC_RST_BYTE;
            irq_mask <= 2'h0;
            irq_status <= 2'h0;
            fall_flag <= 1'b0;
            rise_flag <= 1'b0;
            filt_prev <= 1'b0;
            demod_edge <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            filt_prev <= filt_q;
            demod_edge <= fall_ev | rise_ev;
            // pin follows port latch or combined output
            if (!mode && shared_timer_ctrl[`STC_B_PINEN])
                timer_output_pin <= comb;
            else
                timer_output_pin <= port_out_val;
            if (wr && addr == `STC_OFF_NARROW_CTRL)
                narrow_timer_control <= wdata;
            if (wr && addr == `STC_OFF_WIDE_CTRL)
                wide_timer_control <= wdata;
            if (wr && addr == `STC_OFF_IRQ_MASK)
                irq_mask <= wdata[1:0];
            // mode bit only moves while both counters are stopped
            if (wr_shared) begin
                shared_timer_ctrl[`STC_F_FILT_HI:`STC_B_INSEL]
                    <= wdata[`STC_F_FILT_HI:`STC_B_INSEL];
                if (!(narrow_run || wide_run))
                    shared_timer_ctrl[`STC_B_MODE] <= wdata[`STC_B_MODE];
                if (!mode) begin
                    shared_timer_ctrl[`STC_B_WIDE_INIT] <= wdata[`STC_B_WIDE_INIT];
                    shared_timer_ctrl[`STC_B_NARROW_INIT] <= wdata[`STC_B_NARROW_INIT];
                end
            end
            // flags: set wins over write-one clear
            if (fall_ev)
                fall_flag <= 1'b1;
            else if (wr_shared && mode && wdata[`STC_B_FALL])
                fall_flag <= 1'b0;
            if (rise_ev)
                rise_flag <= 1'b1;
            else if (wr_shared && mode && wdata[`STC_B_RISE])
                rise_flag <= 1'b0;
            // sticky status cleared by read, set wins
            irq_status[`STC_IRQ_FALL] <= fall_ev
                | (irq_status[`STC_IRQ_FALL] & ~(rd && addr == `STC_OFF_IRQ_STATUS));
            irq_status[`STC_IRQ_RISE] <= rise_ev
                | (irq_status[`STC_IRQ_RISE] & ~(rd && addr == `STC_OFF_IRQ_STATUS));
        end
    end

    // read mux
    always @* begin
        next_rdata = 8'h00;
        case (addr)
            `STC_OFF_NARROW_CTRL: next_rdata = narrow_timer_control;
            `STC_OFF_SHARED_CTRL: begin
                next_rdata = shared_timer_ctrl;
                if (mode) begin
                    next_rdata[`STC_B_FALL] = fall_flag;
                    next_rdata[`STC_B_RISE] = rise_flag;
                end
            end
            `STC_OFF_WIDE_CTRL: next_rdata = wide_timer_control;
            `STC_OFF_IRQ_STATUS: next_rdata = {6'h00, irq_status};
            `STC_OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            `STC_OFF_TIMER_STATE: next_rdata = {4'h0, narrow_run, wide_run, filt_q, comb};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            rdata <= 8'h00;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end
endmodule // stc_ctrl

// >>> sim/stc_ctrl_chk.sv
module stc_ctrl_chk (
    input wire clk_sys, // system clock
    input wire rstn, // async reset, active low
    input wire [3:0] addr, // register address
    input wire [7:0] wdata, rdata, narrow_timer_control, wide_timer_control, // data bytes
    input wire wr, rd, narrow_timer_output, wide_timer_output, narrow_run, wide_run, // inputs
    input wire port_out_val, demod_input_pin_a, demod_input_pin_b, // pin inputs
    input wire demod_mode, narrow_init, wide_init, pingpong, demod_edge, // mode outputs
    input wire timer_output_pin, timer_output_pin_oe, irq // pin and interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] mask_m;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // copy of the interrupt mask, kept from the writes seen on the bus
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            mask_m <= 2'h0;
        else if (wr && addr == 4'h4)
            mask_m <= wdata[1:0];
    end
    // mode bit, start levels and routing against the control byte, edge pulses against the mode bit and the interrupt
    AST_MODE_HOLD: assert property (!$past(wr && addr == 4'h1) |-> $stable(demod_mode))
        else $error("mode bit moved without a write");
    AST_MODE_LOCK: assert property (wr && addr == 4'h1 && (narrow_run || wide_run)
        |=> $stable(demod_mode)) else $error("mode changed while a counter ran");
    AST_WIDE_INIT: assert property ($past(rd && addr == 4'h1) && !demod_mode
        |-> wide_init == rdata[7]) else $error("wide start level wrong");
    AST_NARROW_INIT: assert property ($past(rd && addr == 4'h1) && !demod_mode
        |-> narrow_init == rdata[6]) else $error("narrow start level wrong");
    AST_PINGPONG: assert property ($past(rd && addr == 4'h1)
        |-> pingpong == (!rdata[0] && rdata[5:4] == 2'h1)) else $error("ping-pong flag wrong");
    AST_PORT_PIN: assert property ($past(rd && addr == 4'h1) && rdata[1:0] == 2'h0
        |-> timer_output_pin == $past(port_out_val)) else $error("pin not port value");
    AST_EDGE_MODE: assert property (demod_edge |-> $past(demod_mode))
        else $error("edge pulse in transmit mode");
    AST_EDGE_IRQ: assert property (demod_edge && mask_m == 2'h3 |-> irq)
        else $error("edge pulse without interrupt");
endmodule // stc_ctrl_chk
bind stc_ctrl stc_ctrl_chk i_stc_ctrl_chk (.*);

// >>> sim/stc_src.sv
module stc_src (
    input wire clk_sys, // system clock
    input wire lvl, // level to send
    input wire use_b, // send on pin b
    output logic pin_a, // demod pin a
    output logic pin_b // demod pin b
);
    timeunit 1ns;
    timeprecision 1ns;
    // the unused pin toggles each cycle so a wrong input pick shows edges
    initial {pin_a, pin_b} = 2'h0;
    always @(posedge clk_sys) begin
        pin_a <= use_b ? !pin_a : lvl;
        pin_b <= use_b ? lvl : !pin_b;
    end
endmodule // stc_src

// >>> sim/tb_stc_ctrl.sv
module tb_stc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, lvl = 1'b0, use_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic narrow_timer_output = 1'b0, wide_timer_output = 1'b0, port_out_val = 1'b1;
    logic narrow_run = 1'b0, wide_run = 1'b0;
    wire demod_input_pin_a, demod_input_pin_b, demod_mode, narrow_init, wide_init, pingpong;
    wire demod_edge, timer_output_pin, timer_output_pin_oe, irq;
    wire [7:0] rdata, narrow_timer_control, wide_timer_control;
    int err_count = 0;
    int checked = 0;
    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;
    stc_ctrl i_stc_ctrl (.*);
    stc_src i_stc_src (.clk_sys(clk_sys), .lvl(lvl), .use_b(use_b),
        .pin_a(demod_input_pin_a), .pin_b(demod_input_pin_b));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data checked in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        {rd, addr} <= {1'b1, a};
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // high pulse of n cycles on the demod source, then settle
    task automatic pulse(input int n);
        lvl <= 1'b1;
        repeat (n) @(posedge clk_sys);
        lvl <= 1'b0;
        repeat (16) @(posedge clk_sys);
    endtask
    // verdict and end of run
    task automatic report_and_stop;
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd_chk(4'h1, 8'h00);
        chk(timer_output_pin, 1'b1);
        chk(timer_output_pin_oe, 1'b1);
        wr_reg(4'h2, 8'h5A);
        chk(wide_timer_control, 8'h5A);
        rd_chk(4'h2, 8'h5A);
        wr_reg(4'h0, 8'hA5);
        chk(narrow_timer_control, 8'hA5);
        rd_chk(4'h0, 8'hA5);
        rd_chk(4'hF, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h1, {i[1:0], 6'h00});
            chk({wide_init, narrow_init}, i[1:0]);
        end
        for (int c = 0; c < 16; c++) begin
            {wide_timer_output, narrow_timer_output} <= c[1:0];
            wr_reg(4'h1, {4'h0, c[3:2], 2'h2});
            repeat (2) @(posedge clk_sys);
            #1 chk(timer_output_pin, c[3] ^ ((c[2] ^ c[3]) ? |c[1:0] : &c[1:0]));
        end
        for (int f = 2; f < 4; f++) begin
            {wide_timer_output, narrow_timer_output} <= {!f[0], 1'b1};
            wr_reg(4'h1, {2'h0, f[1:0], 4'h2});
            repeat (2) @(posedge clk_sys);
            #1 chk(timer_output_pin, f[0]);
        end
        wr_reg(4'h1, 8'h10);
        chk(pingpong, 1'b1);
        for (int r = 1; r < 3; r++) begin
            {wide_run, narrow_run} <= r[1:0];
            wr_reg(4'h1, 8'h01);
            rd_chk(4'h1, 8'h00);
        end
        {wide_run, narrow_run} <= 2'h0;
        for (int e = 0; e < 3; e++) begin
            use_b <= e[0];
            wr_reg(4'h1, {4'hC, 2'h3, e[0], 1'b1});
            repeat (12) @(posedge clk_sys);
            wr_reg(4'h1, {4'hC, e[1:0], e[0], 1'b1});
            pulse(10);
            rd_chk(4'h1, {e != 1, e != 0, 2'h0, e[1:0], e[0], 1'b1});
        end
        for (int f = 1; f < 3; f++) begin
            wr_reg(4'h1, {2'h3, f[1:0], 4'h5});
            pulse(4 * f - 1);
            rd_chk(4'h1, {2'h0, f[1:0], 4'h5});
            pulse(4 * f + 2);
            rd_chk(4'h1, {2'h1, f[1:0], 4'h5});
        end
        rd_chk(4'h3, 8'h03);
        wr_reg(4'h1, 8'h01);
        rd_chk(4'h1, 8'h41);
        wr_reg(4'h4, 8'h03);
        pulse(10);
        #1 chk(irq, 1'b1);
        wr_reg(4'h1, 8'h41);
        rd_chk(4'h1, 8'h81);
        wr_reg(4'h1, 8'h81);
        rd_chk(4'h1, 8'h01);
        rd_chk(4'h3, 8'h01);
        chk(irq, 1'b0);
        {wide_run, narrow_run} <= 2'h3;
        port_out_val <= 1'b0;
        rd_chk(4'h5, 8'h0C);
        chk(timer_output_pin, 1'b0);
        report_and_stop;
    end
    // watchdog against a hang
    initial begin
        #20000;
        err_count++;
        report_and_stop;
    end
endmodule // tb_stc_ctrl
